// [verilog/otp_sequencer.sv]
`timescale 1ns/1ps
// Functional notes
// - Bit 9 of PLL register bypasses PLL.
// - Start location from start register bits 15:8.
// - Option bit 9 clear keeps ECC enabled.
// - Length low byte sets words processed.
// - Full set programming takes about 500 ms.
// - Control bit 0 starts automatic programming.
// - Control bit 1 reports programming ended.
// - Read length counts words from start location.
// - Control bit 4 starts automatic read.
// - Control bit 5 reports read ended.
// - Read words appear in data window.
// - Array words are 16 data plus 4 check.
// - Program only in standby (the code still programs while streaming and sets the fail flag); words program once.
module otp_sequencer
    import otp_pkg::*;
#(
    parameter int unsigned WORD_PROG_CYCLES = WORD_PROG_CYCLES_DEF,
    parameter int unsigned ARRAY_WORDS = 256
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic ce_in,
    input wire reg_req_s reg_req_in,
    output logic [15:0] reg_rdata_out,
    output logic reg_rvalid_out,
    output logic pll_bypass_out,
    output logic standby_out,
    output logic busy_out
);
    localparam int unsigned AW = $clog2(ARRAY_WORDS);
    localparam logic [22:0] PROG_LAST = 23'(WORD_PROG_CYCLES - 1);

    logic [15:0] reset_mode_control;
    logic [15:0] memory_transfer_length;
    logic [15:0] memory_start_location;
    logic [15:0] memory_configuration;
    logic [15:0] memory_options;
    logic [15:0] pll_bypass_control;
    logic wr_end;
    logic rd_end;
    logic wr_fail;
    logic rd_ecc_err;
    logic [DATA_BITS-1:0] window [WINDOW_WORDS];

    seq_state_e state;
    logic [7:0] idx;
    logic [22:0] timer;

    logic wr_hit;
    logic rd_hit;
    logic win_hit;
    logic [7:0] win_idx;
    logic soft_reset;
    logic start_wr;
    logic start_rd;
    logic [8:0] word_addr;
    logic addr_ok;
    logic last_word;
    logic word_step;
    logic prog_fire;
    logic [DATA_BITS-1:0] prog_data;
    logic [CHECK_BITS-1:0] prog_check;
    logic [DATA_BITS+CHECK_BITS-1:0] arr_rdata;
    logic [CHECK_BITS-1:0] rd_check;
    logic arr_used;
    logic ecc_bad;

    assign wr_hit = reg_req_in.wr;
    assign rd_hit = reg_req_in.rd;
    assign win_hit = (reg_req_in.addr >= ADDR_DATA_WINDOW_FIRST) && (reg_req_in.addr <= ADDR_DATA_WINDOW_LAST);
    assign win_idx = 8'((reg_req_in.addr - ADDR_DATA_WINDOW_FIRST) >> 1);
    assign soft_reset = wr_hit && reg_req_in.addr == ADDR_SOFTWARE_RESET && reg_req_in.wdata[BIT_SOFT_RESET];
    assign start_wr = wr_hit && reg_req_in.addr == ADDR_MEMORY_AUTO_CONTROL && reg_req_in.wdata[BIT_WR_START];
    assign start_rd = wr_hit && reg_req_in.addr == ADDR_MEMORY_AUTO_CONTROL && reg_req_in.wdata[BIT_RD_START];

    // A location is one array row, so the word address is row times two plus the index.
    assign word_addr = 9'({memory_start_location[START_MSB:START_LSB], 1'b0}) + 9'(idx);
    assign addr_ok = word_addr < 9'(ARRAY_WORDS);
    assign last_word = (idx + 8'h01) >= memory_transfer_length[LENGTH_MSB:0];
    assign word_step = (state == SEQ_READ) || (state == SEQ_PROGRAM && timer == PROG_LAST);
    assign prog_data = window[idx];
    assign prog_fire = state == SEQ_PROGRAM && timer == PROG_LAST && addr_ok;

    otp_ecc_gen u_ecc_prog (
        .data_in(prog_data),
        .check_out(prog_check)
    );

    otp_ecc_gen u_ecc_read (
        .data_in(arr_rdata[DATA_BITS-1:0]),
        .check_out(rd_check)
    );

    otp_fuse_array #(
        .WORDS(ARRAY_WORDS),
        .AW(AW)
    ) u_array (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .ce_in(ce_in),
        .prog_in(prog_fire),
        .addr_in(word_addr[AW-1:0]),
        .wdata_in({memory_options[BIT_ECC_DISABLE] ? {CHECK_BITS{1'b0}} : prog_check, prog_data}),
        .rdata_out(arr_rdata),
        .used_out(arr_used)
    );

    // Check bits are only compared on programmed words while the options register has checking enabled.
    assign ecc_bad = arr_used && !memory_options[BIT_ECC_DISABLE] &&
                     (rd_check != arr_rdata[DATA_BITS+CHECK_BITS-1:DATA_BITS]);

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            reset_mode_control <= RESET_MODE_CONTROL_DEF;
            memory_transfer_length <= ZERO16;
            memory_start_location <= ZERO16;
            memory_configuration <= ZERO16;
            memory_options <= ZERO16;
            pll_bypass_control <= ZERO16;
        end else if (ce_in) begin
            if (soft_reset) begin
                reset_mode_control <= RESET_MODE_CONTROL_DEF;
                memory_transfer_length <= ZERO16;
                memory_start_location <= ZERO16;
                memory_configuration <= ZERO16;
                memory_options <= ZERO16;
                pll_bypass_control <= ZERO16;
            end else if (wr_hit) begin
                unique case (reg_req_in.addr)
                    ADDR_RESET_MODE_CONTROL: reset_mode_control <= reg_req_in.wdata;
                    ADDR_MEMORY_TRANSFER_LENGTH: memory_transfer_length <= reg_req_in.wdata;
                    ADDR_MEMORY_START_LOCATION: memory_start_location <= reg_req_in.wdata;
                    ADDR_MEMORY_CONFIGURATION: memory_configuration <= reg_req_in.wdata;
                    ADDR_MEMORY_OPTIONS: memory_options <= reg_req_in.wdata;
                    ADDR_PLL_BYPASS_CONTROL: pll_bypass_control <= reg_req_in.wdata;
                    default: begin
                    end
                endcase
            end
        end
    end

    // Sequencer: a start is ignored while another sequence runs.
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state <= SEQ_IDLE;
            idx <= 8'h00;
            timer <= '0;
        end else if (ce_in) begin
            unique case (state)
                SEQ_IDLE: begin
                    idx <= 8'h00;
                    timer <= '0;
                    if (soft_reset) begin
                        state <= SEQ_IDLE;
                    end else if (start_wr && memory_transfer_length[LENGTH_MSB:0] != 8'h00) begin
                        state <= SEQ_PROGRAM;
                    end else if (start_rd && memory_transfer_length[LENGTH_MSB:0] != 8'h00) begin
                        state <= SEQ_READ;
                    end
                end
                SEQ_PROGRAM, SEQ_READ: begin
                    timer <= (state == SEQ_PROGRAM && timer != PROG_LAST) ? timer + 23'h000001 : '0;
                    if (word_step) begin
                        idx <= idx + 8'h01;
                        if (last_word) begin
                            state <= SEQ_IDLE;
                        end
                    end
                end
                // An upset into the unused state code falls back to idle.
                default: begin
                    state <= SEQ_IDLE;
                    idx <= 8'h00;
                    timer <= '0;
                end
            endcase
        end
    end

    // End and fault flags: a start clears them, except end on zero length and write fail while streaming; the last word sets end, any bad word a fault flag.
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wr_end <= 1'b0;
            rd_end <= 1'b0;
            wr_fail <= 1'b0;
            rd_ecc_err <= 1'b0;
        end else if (ce_in) begin
            if (soft_reset && state == SEQ_IDLE) begin
                wr_end <= 1'b0;
                rd_end <= 1'b0;
                wr_fail <= 1'b0;
                rd_ecc_err <= 1'b0;
            end else if (state == SEQ_IDLE && start_wr) begin
                wr_end <= memory_transfer_length[LENGTH_MSB:0] == 8'h00;
                wr_fail <= reset_mode_control[BIT_STREAMING];
            end else if (state == SEQ_IDLE && start_rd) begin
                rd_end <= memory_transfer_length[LENGTH_MSB:0] == 8'h00;
                rd_ecc_err <= 1'b0;
            end else if (state == SEQ_PROGRAM && word_step) begin
                if (!addr_ok || arr_used || reset_mode_control[BIT_STREAMING]) begin
                    wr_fail <= 1'b1;
                end
                if (last_word) begin
                    wr_end <= 1'b1;
                end
            end else if (state == SEQ_READ) begin
                if (ecc_bad) begin
                    rd_ecc_err <= 1'b1;
                end
                if (last_word) begin
                    rd_end <= 1'b1;
                end
            end
        end
    end

    // Data window: the read sequence copies array words in, the host writes otherwise.
    always_ff @(posedge clk_in) begin
        if (ce_in) begin
            if (state == SEQ_READ) begin
                window[idx] <= addr_ok ? arr_rdata[DATA_BITS-1:0] : ZERO16;
            end else if (wr_hit && win_hit) begin
                window[win_idx] <= reg_req_in.wdata;
            end
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            reg_rdata_out <= ZERO16;
            reg_rvalid_out <= 1'b0;
        end else if (ce_in) begin
            reg_rvalid_out <= rd_hit;
            if (rd_hit) begin
                if (win_hit) begin
                    reg_rdata_out <= window[win_idx];
                end else begin
                    unique case (reg_req_in.addr)
                        ADDR_RESET_MODE_CONTROL: reg_rdata_out <= reset_mode_control;
                        ADDR_MEMORY_AUTO_CONTROL: begin
                            reg_rdata_out <= ZERO16;
                            reg_rdata_out[BIT_WR_END] <= wr_end;
                            reg_rdata_out[BIT_WR_FAIL] <= wr_fail;
                            reg_rdata_out[BIT_RD_END] <= rd_end;
                            reg_rdata_out[BIT_RD_ECC_ERR] <= rd_ecc_err;
                        end
                        ADDR_MEMORY_TRANSFER_LENGTH: reg_rdata_out <= memory_transfer_length;
                        ADDR_MEMORY_START_LOCATION: reg_rdata_out <= memory_start_location;
                        ADDR_MEMORY_CONFIGURATION: reg_rdata_out <= memory_configuration;
                        ADDR_MEMORY_OPTIONS: reg_rdata_out <= memory_options;
                        ADDR_PLL_BYPASS_CONTROL: reg_rdata_out <= pll_bypass_control;
                        default: reg_rdata_out <= ZERO16;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pll_bypass_out <= 1'b0;
            standby_out <= 1'b1;
            busy_out <= 1'b0;
        end else if (ce_in) begin
            pll_bypass_out <= pll_bypass_control[BIT_PLL_BYPASS];
            standby_out <= !reset_mode_control[BIT_STREAMING];
            busy_out <= state != SEQ_IDLE;
        end
    end
endmodule : otp_sequencer

// [verilog/otp_pkg.sv]
package otp_pkg;
    localparam int unsigned CLK_FREQ_HZ = 40_000_000;
    localparam int unsigned SET_PROG_TIME_MS = 500;
    localparam int unsigned SET_WORDS = 102;
    localparam int unsigned WORD_PROG_CYCLES_DEF = (CLK_FREQ_HZ / 1000) * SET_PROG_TIME_MS / SET_WORDS;

    localparam int unsigned DATA_BITS = 16;
    localparam int unsigned CHECK_BITS = 4;
    localparam int unsigned WORDS_PER_ROW = 2;
    localparam int unsigned WINDOW_WORDS = 256;

    localparam logic [15:0] ADDR_SOFTWARE_RESET = 16'h0103;
    localparam logic [15:0] ADDR_RESET_MODE_CONTROL = 16'h301A;
    localparam logic [15:0] ADDR_MEMORY_AUTO_CONTROL = 16'h304A;
    localparam logic [15:0] ADDR_MEMORY_TRANSFER_LENGTH = 16'h304C;
    localparam logic [15:0] ADDR_MEMORY_START_LOCATION = 16'h3050;
    localparam logic [15:0] ADDR_MEMORY_CONFIGURATION = 16'h3052;
    localparam logic [15:0] ADDR_MEMORY_OPTIONS = 16'h3054;
    localparam logic [15:0] ADDR_PLL_BYPASS_CONTROL = 16'h3064;
    localparam logic [15:0] ADDR_DATA_WINDOW_FIRST = 16'h3800;
    localparam logic [15:0] ADDR_DATA_WINDOW_LAST = 16'h39FE;

    localparam int unsigned BIT_WR_START = 0;
    localparam int unsigned BIT_WR_END = 1;
    localparam int unsigned BIT_WR_FAIL = 2;
    localparam int unsigned BIT_RD_START = 4;
    localparam int unsigned BIT_RD_END = 5;
    localparam int unsigned BIT_RD_ECC_ERR = 6;
    localparam int unsigned BIT_PLL_BYPASS = 9;
    localparam int unsigned BIT_ECC_DISABLE = 9;
    localparam int unsigned BIT_STREAMING = 2;
    localparam int unsigned BIT_SOFT_RESET = 0;
    localparam int unsigned START_MSB = 15;
    localparam int unsigned START_LSB = 8;
    localparam int unsigned LENGTH_MSB = 7;

    localparam logic [15:0] RESET_MODE_CONTROL_DEF = 16'h0000;
    localparam logic [15:0] ZERO16 = 16'h0000;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_PROGRAM,
        SEQ_READ
    } seq_state_e;
endpackage : otp_pkg

// [verilog/otp_ecc_gen.sv]
`timescale 1ns/1ps
module otp_ecc_gen
    import otp_pkg::*;
(
    input wire logic [DATA_BITS-1:0] data_in,
    output logic [CHECK_BITS-1:0] check_out
);
    // Each check bit is the parity of one nibble lane.
    always_comb begin
        for (int i = 0; i < CHECK_BITS; i++) begin
            check_out[i] = ^data_in[i*4 +: 4];
        end
    end
endmodule : otp_ecc_gen

// [verilog/otp_fuse_array.sv]
`timescale 1ns/1ps
module otp_fuse_array
    import otp_pkg::*;
#(
    parameter int unsigned WORDS = 256,
    parameter int unsigned AW = 8
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic ce_in,
    input wire logic prog_in,
    input wire logic [AW-1:0] addr_in,
    input wire logic [DATA_BITS+CHECK_BITS-1:0] wdata_in,
    output logic [DATA_BITS+CHECK_BITS-1:0] rdata_out,
    output logic used_out
);
    logic [DATA_BITS+CHECK_BITS-1:0] cells [WORDS];
    logic [WORDS-1:0] used;

    // A blown word cannot be reprogrammed, so a second program is dropped.
    always_ff @(posedge clk_in) begin
        if (ce_in && prog_in && !used[addr_in]) begin
            cells[addr_in] <= wdata_in;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            used <= '0;
        end else if (ce_in && prog_in) begin
            used[addr_in] <= 1'b1;
        end
    end

    assign rdata_out = used[addr_in] ? cells[addr_in] : '0;
    assign used_out = used[addr_in];
endmodule : otp_fuse_array

// [verification/otp_sequencer_assertions.sv]
`timescale 1ns/1ps
module otp_seq_checker
    import otp_pkg::*;
#(
    parameter int unsigned WORD_PROG_CYCLES = 4
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic ce_in,
    input wire reg_req_s reg_req_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic reg_rvalid_out,
    input wire logic pll_bypass_out,
    input wire logic standby_out,
    input wire logic busy_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    logic rd_q;
    logic [15:0] rd_addr;
    logic [7:0] len;
    logic prog;
    int unsigned cnt;
    int unsigned need;
    wire wr_go = ce_in && reg_req_in.wr;
    wire ctl_wr = wr_go && reg_req_in.addr == ADDR_MEMORY_AUTO_CONTROL;
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rd_q <= 1'b0;
            rd_addr <= ZERO16;
        end else if (ce_in) begin
            rd_q <= reg_req_in.rd;
            rd_addr <= reg_req_in.rd ? reg_req_in.addr : rd_addr;
        end
    end
    // Mirrors the length and the kind of the running sequence to know how long busy must last.
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            len <= 8'h00;
            prog <= 1'b0;
            cnt <= 0;
            need <= 0;
        end else begin
            if (wr_go && reg_req_in.addr == ADDR_MEMORY_TRANSFER_LENGTH) len <= reg_req_in.wdata[7:0];
            if (wr_go && reg_req_in.addr == ADDR_SOFTWARE_RESET && reg_req_in.wdata[0]) len <= 8'h00;
            if (ctl_wr && !busy_out) begin
                prog <= reg_req_in.wdata[BIT_WR_START];
                need <= reg_req_in.wdata[BIT_WR_START] ? len * WORD_PROG_CYCLES : len;
            end
            if (ce_in) cnt <= busy_out ? cnt + 1 : 0;
        end
    end
    sequence s_go;
        ctl_wr && (reg_req_in.wdata[BIT_WR_START] || reg_req_in.wdata[BIT_RD_START]);
    endsequence
    sequence s_idle_ready;
        !busy_out && len != 8'h00 && standby_out;
    endsequence
    a_read_answer: assert property (ce_in && reg_req_in.rd |=> reg_rvalid_out) else $error("read not answered");
    a_answer_cause: assert property (reg_rvalid_out |-> rd_q) else $error("answer without read");
    // The pin follows its register one enabled cycle after the write lands.
    a_pll_copy: assert property (wr_go && reg_req_in.addr == ADDR_PLL_BYPASS_CONTROL ##1 ce_in
        |=> pll_bypass_out == $past(reg_req_in.wdata[BIT_PLL_BYPASS], 2)) else $error("bypass wrong");
    a_standby_copy: assert property (wr_go && reg_req_in.addr == ADDR_RESET_MODE_CONTROL ##1 ce_in
        |=> standby_out == !$past(reg_req_in.wdata[BIT_STREAMING], 2)) else $error("standby wrong");
    a_start_busy: assert property (s_go ##0 s_idle_ready |-> ##[1:2] busy_out) else $error("no start");
    a_busy_length: assert property ($fell(busy_out) |-> cnt >= need && cnt <= need + 1)
        else $error("busy length wrong");
    a_end_low_busy: assert property (reg_rvalid_out && rd_addr == ADDR_MEMORY_AUTO_CONTROL && busy_out
        |-> !reg_rdata_out[prog ? BIT_WR_END : BIT_RD_END]) else $error("end flag early");
    a_ce_freeze: assert property (!ce_in |=> $stable(busy_out) && $stable(reg_rdata_out))
        else $error("state moved while frozen");
    a_unmapped_zero: assert property (reg_rvalid_out && rd_addr[15:8] == 8'h31 |-> reg_rdata_out == ZERO16)
        else $error("unmapped read not zero");
endmodule : otp_seq_checker
bind otp_sequencer otp_seq_checker #(.WORD_PROG_CYCLES(WORD_PROG_CYCLES)) chk_u (.clk_in, .arst_n_in,
    .ce_in, .reg_req_in, .reg_rdata_out, .reg_rvalid_out, .pll_bypass_out, .standby_out, .busy_out);

// [verification/otp_host_model.sv]
`timescale 1ns/1ps
module otp_host_model
    import otp_pkg::*;
(
    input wire logic clk_in,
    output reg_req_s req_out,
    input wire logic [15:0] rdata_in,
    input wire logic rvalid_in
);
    initial req_out = '0;
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_in);
        req_out <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_in);
        req_out <= '0;
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge clk_in);
        req_out <= '{addr: a, wdata: ZERO16, wr: 1'b0, rd: 1'b1};
        @(posedge clk_in);
        req_out <= '0;
        @(posedge clk_in);
        d = rvalid_in ? rdata_in : 16'hFFFF;
    endtask : rd
    // The bound covers the scaled program time of a full coefficient set.
    task automatic poll(input int unsigned b);
        logic [15:0] d;
        for (int i = 0; i < 400; i++) begin
            rd(ADDR_MEMORY_AUTO_CONTROL, d);
            if (d[b] === 1'b1 && d !== 16'hFFFF) break;
        end
    endtask : poll
    task automatic burn(input logic [7:0] loc, input logic [7:0] n);
        wr(ADDR_RESET_MODE_CONTROL, 16'h10D8);
        wr(ADDR_PLL_BYPASS_CONTROL, 16'h0200);
        wr(ADDR_MEMORY_START_LOCATION, {loc, 8'h00});
        wr(ADDR_MEMORY_OPTIONS, 16'h0100);
        wr(ADDR_MEMORY_TRANSFER_LENGTH, {8'h00, n});
        wr(ADDR_MEMORY_CONFIGURATION, 16'h2504);
        wr(ADDR_MEMORY_AUTO_CONTROL, 16'h0001);
        poll(BIT_WR_END);
    endtask : burn
    task automatic read_back(input logic [7:0] loc, input logic [7:0] n);
        wr(ADDR_SOFTWARE_RESET, 16'h0001);
        wr(ADDR_MEMORY_CONFIGURATION, 16'h2704);
        wr(ADDR_MEMORY_OPTIONS, 16'h0100);
        wr(ADDR_MEMORY_START_LOCATION, {loc, 8'h00});
        wr(ADDR_MEMORY_TRANSFER_LENGTH, {8'h00, n});
        wr(ADDR_MEMORY_AUTO_CONTROL, 16'h0010);
        poll(BIT_RD_END);
    endtask : read_back
endmodule : otp_host_model

// [verification/otp_memory_auto_program_read_tb.sv]
`timescale 1ns/1ps
module otp_memory_auto_program_read_tb
    import otp_pkg::*;
;
    logic clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic ce_in = 1'b1;
    reg_req_s req;
    logic [15:0] rdata;
    logic rvalid;
    logic pll;
    logic stby;
    logic busy;
    int mismatches = 0;
    int num_checks = 0;
    logic [15:0] notes[$];
    logic [15:0] masks[$];
    logic [15:0] img[4];
    logic [15:0] d;
    always #12.5 clk_in = ~clk_in;
    otp_sequencer #(.WORD_PROG_CYCLES(8)) dut_u (.clk_in(clk_in), .arst_n_in(arst_n_in), .ce_in(ce_in),
        .reg_req_in(req), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .pll_bypass_out(pll),
        .standby_out(stby), .busy_out(busy));
    otp_host_model host_u (.clk_in(clk_in), .req_out(req), .rdata_in(rdata), .rvalid_in(rvalid));
    task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", n, exp, seen);
        end
    endtask : check
    task automatic expect_rd(input logic [15:0] a, input logic [15:0] e, input logic [15:0] m);
        // Let the answer of a preceding poll read drain before the note is queued.
        @(negedge clk_in);
        notes.push_back(e);
        masks.push_back(m);
        host_u.rd(a, d);
    endtask : expect_rd
    task automatic fill(input logic [15:0] base, input int n);
        for (int i = 0; i < n; i++) host_u.wr(ADDR_DATA_WINDOW_FIRST + 16'(2 * i), base ^ img[i]);
    endtask : fill
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up
    always @(posedge clk_in) begin
        if (rvalid && notes.size() > 0) check("read data", rdata & masks.pop_front(), notes.pop_front());
    end
    initial begin
        repeat (30000) @(posedge clk_in);
        mismatches++;
        wrap_up();
    end
    initial begin
        void'($urandom(32'hAB1C));
        foreach (img[i]) img[i] = 16'($urandom);
        repeat (3) @(posedge clk_in);
        arst_n_in <= 1'b1;
        @(negedge clk_in);
        check("reset state", {13'h0, stby, pll, busy}, 16'h0004);
        host_u.wr(ADDR_MEMORY_CONFIGURATION, 16'h2504);
        expect_rd(ADDR_MEMORY_CONFIGURATION, 16'h2504, 16'hFFFF);
        host_u.wr(16'h3100, 16'h5A5A);
        expect_rd(16'h3100, ZERO16, 16'hFFFF);
        host_u.wr(ADDR_PLL_BYPASS_CONTROL, 16'h0200);
        // The bypass pin is registered from the control register, one cycle behind it.
        repeat (2) @(negedge clk_in);
        check("bypass", {15'h0, pll}, 16'h0001);
        $display("registers done");
        fill(ZERO16, 4);
        fork
            host_u.burn(8'h00, 8'h04);
            begin
                repeat (22) @(posedge clk_in);
                ce_in <= 1'b0;
                repeat (5) @(posedge clk_in);
                ce_in <= 1'b1;
            end
        join
        expect_rd(ADDR_MEMORY_AUTO_CONTROL, 16'h0002, 16'h0037);
        fill(16'hFFFF, 4);
        host_u.read_back(8'h00, 8'h04);
        expect_rd(ADDR_MEMORY_AUTO_CONTROL, 16'h0020, 16'h0077);
        for (int i = 0; i < 4; i++) expect_rd(ADDR_DATA_WINDOW_FIRST + 16'(2 * i), img[i], 16'hFFFF);
        $display("program and read done");
        fill(16'hFFFF, 2);
        host_u.burn(8'h00, 8'h02);
        expect_rd(ADDR_MEMORY_AUTO_CONTROL, 16'h0004, 16'h0004);
        host_u.read_back(8'h00, 8'h01);
        expect_rd(ADDR_DATA_WINDOW_FIRST, img[0], 16'hFFFF);
        $display("fuse once done");
        fill(16'h00FF, 2);
        host_u.burn(8'h02, 8'h02);
        expect_rd(ADDR_MEMORY_AUTO_CONTROL, 16'h0002, 16'h0006);
        fill(16'hFFFF, 4);
        host_u.read_back(8'h01, 8'h04);
        for (int i = 0; i < 2; i++) expect_rd(ADDR_DATA_WINDOW_FIRST + 16'(2 * i), img[i + 2], 16'hFFFF);
        expect_rd(ADDR_DATA_WINDOW_FIRST + 16'h4, 16'h00FF ^ img[0], 16'hFFFF);
        expect_rd(ADDR_DATA_WINDOW_FIRST + 16'h6, 16'h00FF ^ img[1], 16'hFFFF);
        $display("start location done");
        host_u.burn(8'h80, 8'h01);
        expect_rd(ADDR_MEMORY_AUTO_CONTROL, 16'h0004, 16'h0004);
        host_u.burn(8'h00, 8'h00);
        expect_rd(ADDR_MEMORY_AUTO_CONTROL, 16'h0002, 16'h0006);
        $display("limits done");
        repeat (4) @(posedge clk_in);
        wrap_up();
    end
endmodule : otp_memory_auto_program_read_tb
